// *** hdl/bcp_pkg.sv ***
package bcp_pkg;

	// Register byte addresses on the AXI4-Lite slave.
	localparam logic [7:0] BCP_ADDR_LOCK    = 8'h00;
	localparam logic [7:0] BCP_ADDR_CTRL    = 8'h04;
	localparam logic [7:0] BCP_ADDR_SCTIME  = 8'h08;
	localparam logic [7:0] BCP_ADDR_OCTIME  = 8'h0C;
	localparam logic [7:0] BCP_ADDR_HCTIME  = 8'h10;
	localparam logic [7:0] BCP_ADDR_UVPARAM = 8'h14;
	localparam logic [7:0] BCP_ADDR_SWITCH  = 8'h18;
	localparam logic [7:0] BCP_ADDR_FLAGS   = 8'h1C;
	localparam logic [7:0] BCP_ADDR_IRQEN   = 8'h20;
	localparam logic [7:0] BCP_ADDR_STATUS  = 8'h24;

	// Protection indices in flag, enable and control vectors.
	localparam int BCP_SC  = 0;
	localparam int BCP_DOC = 1;
	localparam int BCP_COC = 2;
	localparam int BCP_DHC = 3;
	localparam int BCP_CHC = 4;
	localparam int BCP_UVE = 5;
	localparam int BCP_UVX = 6;
	localparam int BCP_NPROT = 5;

	// Lock register fields.
	localparam int BCP_LOCK_BIT = 0;
	localparam int BCP_ARM_BIT  = 1;
	localparam int BCP_BUSY_BIT = 2;
	localparam int BCP_LOCK_WINDOW = 4;

	// Switch control register fields.
	localparam int BCP_SW_DIS = 0;
	localparam int BCP_SW_CHG = 1;
	localparam int BCP_SW_PRE = 2;
	localparam int BCP_SW_REC = 3;

	// Reset values of parameters.
	localparam logic [5:0] BCP_CTRL_RST   = 6'h3F;
	localparam logic [6:0] BCP_SCTIME_RST = 7'h10;
	localparam logic [5:0] BCP_OCTIME_RST = 6'h01;
	localparam logic [5:0] BCP_HCTIME_RST = 6'h01;
	localparam logic [15:0] BCP_UV_RST    = 16'h0000;

	// Oscillator tick weights per timing step, in oscillator ticks.
	localparam logic [15:0] BCP_SC_STEP = 16'h0001;
	localparam logic [15:0] BCP_OC_STEP = 16'h0008;
	localparam logic [15:0] BCP_HC_STEP = 16'h0020;
	localparam logic [15:0] BCP_UV_STEP = 16'h0080;

	// Guard time and timers.
	localparam int BCP_GUARD_OSC = 3;
	localparam int BCP_GUARD_CPU = 3;
	localparam int BCP_CLK_HZ = 100_000_000;
	localparam int BCP_HOLDOFF_MS = 1000;
	localparam int BCP_WARN_MS = 750;
	localparam int BCP_HOLDOFF_CYC = BCP_CLK_HZ / 1000 * BCP_HOLDOFF_MS;
	localparam int BCP_WARN_CYC = BCP_CLK_HZ / 1000 * BCP_WARN_MS;

	// AXI response codes.
	localparam logic [1:0] BCP_RESP_OK  = 2'h0;
	localparam logic [1:0] BCP_RESP_ERR = 2'h2;

	// Deep under-voltage sequence.
	typedef enum logic [1:0] {
		BCP_UV_IDLE = 2'b00,
		BCP_UV_WAIT = 2'b01,
		BCP_UV_WARN = 2'b11,
		BCP_UV_OFF  = 2'b10
	} bcp_uv_t;

endpackage : bcp_pkg

// *** hdl/bcp_qualify.sv ***
`timescale 1ns/1ps
`default_nettype none
// Qualifies one synchronised comparator level against a reaction time.
module bcp_qualify
	import bcp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        tick,
	input  wire logic        active,
	input  wire logic        level,
	input  wire logic [22:0] limit,
	output logic             fire
);

	logic [22:0] count;

	// Count oscillator ticks while the level stays high; any drop restarts.
	always_ff @(posedge clk) begin
		if (srst || !active || !level) begin
			count <= '0;
			fire  <= 1'b0;
		end else begin
			fire <= 1'b0;
			if (tick) begin
				if (count > limit) begin
					fire  <= 1'b1;
					count <= '0;
				end else begin
					count <= count + 23'h000001;
				end
			end
		end
	end

endmodule : bcp_qualify
`default_nettype wire

// *** hdl/bcp_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module bcp_top
	import bcp_pkg::*;
#(
	parameter int HOLDOFF_CYC = BCP_HOLDOFF_CYC,
	parameter int WARN_CYC    = BCP_WARN_CYC
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        low_power_osc,
	input  wire logic [4:0]  shunt_sense_inputs,
	input  wire logic        pack_supply_input,
	input  wire logic        charger_detect,
	output logic             discharge_switch,
	output logic             charge_switch,
	output logic             precharge_switch,
	output logic             power_off,
	output logic             undervolt_early_warning_flag,
	output logic             protect_irq
);

	logic [1:0]  osc_sync, osc_prev;
	logic [4:0]  cmp_meta, cmp_sync;
	logic [1:0]  uv_sync, chg_sync;
	logic        osc_tick;
	logic [5:0]  ctrl;
	logic [6:0]  sc_time;
	logic [5:0]  oc_time, hc_time;
	logic [15:0] undervolt_param_reg;
	logic        param_lock, param_lock_arm;
	logic [2:0]  arm_age;
	logic        param_update_busy;
	logic [1:0]  guard_osc;
	logic [1:0]  guard_cpu;
	logic [3:0]  switch_control_status_reg;
	logic [6:0]  flags, irq_en;
	logic [4:0]  trip;
	logic [4:0]  det_on;
	logic        any_trip;
	logic [31:0] hold_cnt;
	logic        holdoff;
	bcp_uv_t     uv_state;
	logic [31:0] uv_cnt;
	logic [22:0] uv_limit;
	logic        aw_held, w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic        wr_go;
	logic        param_addr;
	logic        uv_enter, uv_exit;

	// Scaled limit: a timing field times oscillator ticks per step.
	function automatic logic [22:0] scale(input logic [6:0] f, input logic [15:0] step);
		scale = 23'(f) * 23'(step);
	endfunction : scale

	// Two-stage synchronisers for every asynchronous pin.
	always_ff @(posedge clk) begin
		if (srst) begin
			osc_sync <= '0;
			osc_prev <= '0;
			cmp_meta <= '0;
			cmp_sync <= '0;
			uv_sync  <= '0;
			chg_sync <= '0;
		end else begin
			osc_sync <= {osc_sync[0], low_power_osc};
			osc_prev <= {osc_prev[0], osc_sync[1]};
			cmp_meta <= shunt_sense_inputs;
			cmp_sync <= cmp_meta;
			uv_sync  <= {uv_sync[0], pack_supply_input};
			chg_sync <= {chg_sync[0], charger_detect};
		end
	end

	// Sampling only on oscillator rising edges keeps qualification on that clock.
	assign osc_tick = osc_prev[0] && !osc_prev[1];

	// Detectors follow the switch they protect; recovery keeps charge ones alive.
	// The external protection input is deliberately not an input here.
	always_comb begin
		det_on[BCP_SC]  = discharge_switch && ctrl[BCP_SC];
		det_on[BCP_DOC] = discharge_switch && ctrl[BCP_DOC];
		det_on[BCP_DHC] = discharge_switch && ctrl[BCP_DHC];
		det_on[BCP_COC] = (charge_switch || switch_control_status_reg[BCP_SW_REC]) && ctrl[BCP_COC];
		det_on[BCP_CHC] = (charge_switch || switch_control_status_reg[BCP_SW_REC]) && ctrl[BCP_CHC];
	end

	// One qualifier per level; reaction times are shared in pairs, except the short-circuit one.
	for (genvar i = 0; i < BCP_NPROT; i++) begin : g_qual
		logic [22:0] lim;
		assign lim = (i == BCP_SC) ? scale(sc_time, BCP_SC_STEP) :
			(i == BCP_DOC || i == BCP_COC) ? scale({1'b0, oc_time}, BCP_OC_STEP) :
			scale({1'b0, hc_time}, BCP_HC_STEP);
		bcp_qualify u_qual (
			.clk    (clk),
			.srst   (srst),
			.tick   (osc_tick),
			.active (det_on[i]),
			.level  (cmp_sync[i]),
			.limit  (lim),
			.fire   (trip[i])
		);
	end
	assign any_trip = |trip;

	// Write channel capture: address and data taken in either order.
	always_ff @(posedge clk) begin
		if (srst) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
		end else if (wr_go) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
			end
		end
	end
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign param_addr = aw_addr == BCP_ADDR_CTRL || aw_addr == BCP_ADDR_SCTIME ||
		aw_addr == BCP_ADDR_OCTIME || aw_addr == BCP_ADDR_HCTIME || aw_addr == BCP_ADDR_UVPARAM;

	// Ready and write response handshakes; unmapped addresses answer an error.
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= BCP_RESP_OK;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr <= BCP_ADDR_STATUS && aw_addr[1:0] == 2'h0) ? BCP_RESP_OK : BCP_RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Parameter registers; writes dropped while locked or busy.
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl    <= BCP_CTRL_RST;
			sc_time <= BCP_SCTIME_RST;
			oc_time <= BCP_OCTIME_RST;
			hc_time <= BCP_HCTIME_RST;
			undervolt_param_reg <= BCP_UV_RST;
		end else if (wr_go && !param_lock && !param_update_busy && s_axi_wstrb[0]) begin
			unique case (aw_addr)
				BCP_ADDR_CTRL:    ctrl    <= w_data[5:0];
				BCP_ADDR_SCTIME:  sc_time <= w_data[6:0];
				BCP_ADDR_OCTIME:  oc_time <= w_data[5:0];
				BCP_ADDR_HCTIME:  hc_time <= w_data[5:0];
				BCP_ADDR_UVPARAM: undervolt_param_reg[7:0] <= w_data[7:0];
				default: ;
			endcase
			if (aw_addr == BCP_ADDR_UVPARAM && s_axi_wstrb[1]) begin
				undervolt_param_reg[15:8] <= w_data[15:8];
			end
		end
	end

	// Guard: three oscillator ticks then three clocks after each accepted parameter-register write.
	always_ff @(posedge clk) begin
		if (srst) begin
			param_update_busy <= 1'b0;
			guard_osc <= '0;
			guard_cpu <= '0;
		end else if (wr_go && param_addr && !param_lock && !param_update_busy) begin
			param_update_busy <= 1'b1;
			guard_osc <= 2'(BCP_GUARD_OSC);
			guard_cpu <= 2'(BCP_GUARD_CPU);
		end else if (param_update_busy) begin
			if (guard_osc != 2'h0) begin
				if (osc_tick) guard_osc <= guard_osc - 2'h1;
			end else if (guard_cpu != 2'h0) begin
				guard_cpu <= guard_cpu - 2'h1;
			end else begin
				param_update_busy <= 1'b0;
			end
		end
	end

	// Lock sequence: arm with both ones, then lock alone within the window.
	always_ff @(posedge clk) begin
		if (srst) begin
			param_lock <= 1'b0;
			param_lock_arm <= 1'b0;
			arm_age <= '0;
		end else if (wr_go && aw_addr == BCP_ADDR_LOCK && !param_lock) begin
			if (w_data[BCP_ARM_BIT] && w_data[BCP_LOCK_BIT]) begin
				param_lock_arm <= 1'b1;
				arm_age <= '0;
			end else if (param_lock_arm && w_data[BCP_LOCK_BIT]) begin
				param_lock <= 1'b1;
				param_lock_arm <= 1'b0;
			end else begin
				param_lock_arm <= 1'b0;
			end
		end else if (param_lock_arm) begin
			arm_age <= arm_age + 3'h1;
			if (arm_age == 3'(BCP_LOCK_WINDOW - 1)) param_lock_arm <= 1'b0;
		end
	end

	// Hold-off timer restarts on every trip.
	always_ff @(posedge clk) begin
		if (srst) begin
			hold_cnt <= '0;
		end else if (any_trip) begin
			hold_cnt <= 32'(HOLDOFF_CYC);
		end else if (hold_cnt != 32'h0) begin
			hold_cnt <= hold_cnt - 32'h1;
		end
	end
	assign holdoff = hold_cnt != 32'h0;

	// Switch enables: trips and power-off win; software only re-enables after hold-off.
	always_ff @(posedge clk) begin
		if (srst) begin
			switch_control_status_reg <= 4'h0;
		end else if (uv_state == BCP_UV_OFF) begin
			switch_control_status_reg <= 4'h0;
		end else if (any_trip) begin
			switch_control_status_reg[BCP_SW_DIS] <= 1'b0;
			switch_control_status_reg[BCP_SW_CHG] <= 1'b0;
		end else if (wr_go && aw_addr == BCP_ADDR_SWITCH) begin
			switch_control_status_reg[BCP_SW_PRE] <= w_data[BCP_SW_PRE];
			switch_control_status_reg[BCP_SW_REC] <= w_data[BCP_SW_REC];
			if (!holdoff) begin
				switch_control_status_reg[BCP_SW_DIS] <= w_data[BCP_SW_DIS];
				switch_control_status_reg[BCP_SW_CHG] <= w_data[BCP_SW_CHG];
			end
		end
	end
	assign discharge_switch = switch_control_status_reg[BCP_SW_DIS];
	assign charge_switch    = switch_control_status_reg[BCP_SW_CHG];
	assign precharge_switch = switch_control_status_reg[BCP_SW_PRE];

	// Deep under-voltage: delay from the parameter register, warning, then off.
	assign uv_limit = scale(undervolt_param_reg[14:8], BCP_UV_STEP);
	always_ff @(posedge clk) begin
		if (srst) begin
			uv_state <= BCP_UV_IDLE;
			uv_cnt   <= '0;
		end else begin
			unique case (uv_state)
				BCP_UV_IDLE: begin
					uv_cnt <= '0;
					if (uv_sync[1] && ctrl[BCP_UVE]) uv_state <= BCP_UV_WAIT;
				end
				BCP_UV_WAIT: begin
					if (!uv_sync[1] || !ctrl[BCP_UVE]) begin
						uv_state <= BCP_UV_IDLE;
					end else if (osc_tick) begin
						if (uv_cnt[22:0] > uv_limit) begin
							uv_state <= BCP_UV_WARN;
							uv_cnt   <= '0;
						end else begin
							uv_cnt <= uv_cnt + 32'h1;
						end
					end
				end
				BCP_UV_WARN: begin
					uv_cnt <= uv_cnt + 32'h1;
					if (uv_cnt >= 32'(WARN_CYC - 1)) uv_state <= BCP_UV_OFF;
				end
				BCP_UV_OFF: begin
					if (chg_sync[1]) uv_state <= BCP_UV_IDLE;
				end
			endcase
		end
	end
	// Power-off pin is registered so the pin never glitches while the state code changes.
	always_ff @(posedge clk) begin
		if (srst) begin
			power_off <= 1'b0;
		end else begin
			power_off <= uv_state == BCP_UV_OFF;
		end
	end
	assign undervolt_early_warning_flag = flags[BCP_UVE];

	assign uv_enter = uv_state == BCP_UV_WAIT && osc_tick && uv_cnt[22:0] > uv_limit;
	assign uv_exit  = uv_state == BCP_UV_WARN && !uv_sync[1];

	// Sticky flags: set wins over a zero write; entry only for current trips and under-voltage entry and exit.
	always_ff @(posedge clk) begin
		if (srst) begin
			flags  <= '0;
			irq_en <= '0;
		end else begin
			if (wr_go && aw_addr == BCP_ADDR_IRQEN) irq_en <= w_data[6:0];
			flags <= ((wr_go && aw_addr == BCP_ADDR_FLAGS) ? (flags & w_data[6:0]) : flags)
				| {uv_exit, uv_enter, trip};
		end
	end
	// Interrupt request is registered; it lags the flags by one clock.
	always_ff @(posedge clk) begin
		if (srst) begin
			protect_irq <= 1'b0;
		end else begin
			protect_irq <= |(flags & irq_en);
		end
	end

	// Read channel: one cycle latency, error on unmapped address.
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= BCP_RESP_OK;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= BCP_RESP_OK;
				unique case (s_axi_araddr)
					BCP_ADDR_LOCK:    s_axi_rdata <= {29'h0, param_update_busy, param_lock_arm, param_lock};
					BCP_ADDR_CTRL:    s_axi_rdata <= {26'h0, ctrl};
					BCP_ADDR_SCTIME:  s_axi_rdata <= {25'h0, sc_time};
					BCP_ADDR_OCTIME:  s_axi_rdata <= {26'h0, oc_time};
					BCP_ADDR_HCTIME:  s_axi_rdata <= {26'h0, hc_time};
					BCP_ADDR_UVPARAM: s_axi_rdata <= {16'h0, undervolt_param_reg};
					BCP_ADDR_SWITCH:  s_axi_rdata <= {27'h0, holdoff, switch_control_status_reg};
					BCP_ADDR_FLAGS:   s_axi_rdata <= {25'h0, flags};
					BCP_ADDR_IRQEN:   s_axi_rdata <= {25'h0, irq_en};
					BCP_ADDR_STATUS:  s_axi_rdata <= {24'h0, cmp_sync, power_off, uv_state};
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= BCP_RESP_ERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : bcp_top
`default_nettype wire

// *** sim/bcp_analog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Comparators, supply sensor and oscillator as the block sees them from outside.
module bcp_analog_model #(
	parameter int OSC_DIV = 4
) (
	input  wire logic       clk,
	input  wire logic [4:0] fault_cmd,
	input  wire logic       low_cmd,
	input  wire logic       chg_cmd,
	output var logic        low_power_osc,
	output var logic [4:0]  shunt_sense_inputs,
	output var logic        pack_supply_input,
	output var logic        charger_detect
);
	int div = 0;

	// Levels are known from time zero so the synchronisers never see an unknown.
	initial begin
		low_power_osc = 1'b0;
		shunt_sense_inputs = 5'h00;
		pack_supply_input = 1'b0;
		charger_detect = 1'b0;
	end

	// Sensors follow their commands one edge late; the oscillator runs free, as the real one does.
	always @(posedge clk) begin
		div <= (div == OSC_DIV - 1) ? 0 : div + 1;
		if (div == OSC_DIV - 1) low_power_osc <= ~low_power_osc;
		shunt_sense_inputs <= fault_cmd;
		pack_supply_input <= low_cmd;
		charger_detect <= chg_cmd;
	end
endmodule : bcp_analog_model
`default_nettype wire

// *** sim/bcp_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pin-level watch over trips, hold-off and the deep under-voltage sequence.
module bcp_top_asserts
	import bcp_pkg::*;
#(
	parameter int HOLDOFF_CYC = 200,
	parameter int WARN_CYC    = 100
) (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic       s_axi_awvalid,
	input wire logic [4:0] shunt_sense_inputs,
	input wire logic       charger_detect,
	input wire logic       discharge_switch,
	input wire logic       charge_switch,
	input wire logic       precharge_switch,
	input wire logic       power_off,
	input wire logic       undervolt_early_warning_flag,
	input wire logic       protect_irq
);
	logic       prev_dis;
	logic       prev_chg;
	logic [3:0] sw_age;
	logic [5:0] idle;
	int         hold;
	int         warn;
	logic       hw_fall;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// Software also drops switches, so a drop counts as a trip only after a quiet spell on that register.
	assign hw_fall = sw_age > 4'h8 && !power_off
		&& ((prev_dis && !discharge_switch) || (prev_chg && !charge_switch));

	// Switch history and age of the last switch-register access.
	always_ff @(posedge clk) begin
		prev_dis <= discharge_switch;
		prev_chg <= charge_switch;
		if (srst || (s_axi_awvalid && s_axi_awaddr == BCP_ADDR_SWITCH)) sw_age <= 4'h0;
		else if (sw_age != 4'hF) sw_age <= sw_age + 4'h1;
	end

	// Cycles since a comparator was last high, saturating.
	always_ff @(posedge clk) begin
		if (srst || shunt_sense_inputs != 5'h00) idle <= 6'h00;
		else if (idle != 6'h3F) idle <= idle + 6'h01;
	end

	// Age of the hold-off after a trip, and how long the early warning has stood.
	always_ff @(posedge clk) begin
		if (srst) begin
			hold <= 0;
			warn <= 0;
		end else begin
			if (hw_fall) hold <= 1;
			else if (hold != 0 && hold < HOLDOFF_CYC) hold <= hold + 1;
			if (!undervolt_early_warning_flag) warn <= 0;
			else if (!power_off) warn <= warn + 1;
		end
	end

	sequence s_no_charger;
		!charger_detect [*5];
	endsequence
	sequence s_off_settled;
		power_off ##1 power_off;
	endsequence

	property p_off_cuts;
		s_off_settled |-> !discharge_switch && !charge_switch && !precharge_switch;
	endproperty
	property p_warn_lead;
		$rose(power_off) |-> warn >= WARN_CYC - 2 && warn <= WARN_CYC + 2;
	endproperty
	property p_warn_first;
		$rose(undervolt_early_warning_flag) |-> !power_off [*8];
	endproperty
	property p_stay_off;
		s_no_charger ##0 power_off |=> power_off;
	endproperty
	property p_trip_both;
		hw_fall |-> !discharge_switch && !charge_switch;
	endproperty
	property p_trip_cause;
		hw_fall |-> idle < 6'h08;
	endproperty
	property p_holdoff;
		hold != 0 && hold < HOLDOFF_CYC - 2 |-> !discharge_switch && !charge_switch;
	endproperty
	property p_irq_reset;
		$fell(srst) |-> !protect_irq;
	endproperty

	a_off_cuts: assert property (p_off_cuts) else $error("switch on in power-off");
	a_warn_lead: assert property (p_warn_lead) else $error("warning lead wrong");
	a_warn_first: assert property (p_warn_first) else $error("power-off too soon");
	a_stay_off: assert property (p_stay_off) else $error("left power-off early");
	a_trip_both: assert property (p_trip_both) else $error("trip left a switch on");
	a_trip_cause: assert property (p_trip_cause) else $error("trip without comparator");
	a_holdoff: assert property (p_holdoff) else $error("switch on in hold-off");
	a_irq_reset: assert property (p_irq_reset) else $error("irq after reset");
endmodule : bcp_top_asserts

bind bcp_top bcp_top_asserts #(
	.HOLDOFF_CYC(HOLDOFF_CYC),
	.WARN_CYC   (WARN_CYC)
) bcp_top_asserts_inst (
	.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .shunt_sense_inputs, .charger_detect,
	.discharge_switch, .charge_switch, .precharge_switch, .power_off,
	.undervolt_early_warning_flag, .protect_irq
);
`default_nettype wire

// *** sim/battery_current_protection_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module battery_current_protection_tb
	import bcp_pkg::*;
;
	localparam int OSC_DIV = 4;
	localparam int HOLD    = 200;
	localparam int WARN    = 100;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b0;
	logic        low_power_osc;
	logic [4:0]  shunt_sense_inputs;
	logic        pack_supply_input;
	logic        charger_detect;
	logic        discharge_switch;
	logic        charge_switch;
	logic        precharge_switch;
	logic        power_off;
	logic        undervolt_early_warning_flag;
	logic        protect_irq;
	logic [4:0]  fault_cmd = 5'h00;
	logic        low_cmd = 1'b0;
	logic        chg_cmd = 1'b0;
	int          miscompares = 0;
	int          checks_done = 0;
	int          n;
	logic [31:0] d;
	logic [1:0]  r;
	logic [7:0]  rst_a[9] = '{BCP_ADDR_LOCK, BCP_ADDR_CTRL, BCP_ADDR_SCTIME, BCP_ADDR_OCTIME, BCP_ADDR_HCTIME,
		BCP_ADDR_UVPARAM, BCP_ADDR_SWITCH, BCP_ADDR_FLAGS, BCP_ADDR_IRQEN};
	logic [31:0] rst_v[9] = '{0, BCP_CTRL_RST, BCP_SCTIME_RST, BCP_OCTIME_RST, BCP_HCTIME_RST, BCP_UV_RST, 0, 0, 0};
	int          tk[5] = '{BCP_SCTIME_RST * BCP_SC_STEP, BCP_OCTIME_RST * BCP_OC_STEP, BCP_OCTIME_RST * BCP_OC_STEP,
		BCP_HCTIME_RST * BCP_HC_STEP, BCP_HCTIME_RST * BCP_HC_STEP};

	// Long timers are shortened so the whole run stays brief.
	bcp_top #(.HOLDOFF_CYC(HOLD), .WARN_CYC(WARN)) bcp_top_inst (.*);
	bcp_analog_model #(.OSC_DIV(OSC_DIV)) bcp_analog_model_inst (.*);

	// Free-running 100 MHz clock.
	initial begin
		forever #5 clk = ~clk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Bounded wait on a level; running out ends the run.
	task automatic wait_sig(ref logic s, input logic v, input int lim, output int k, input string nm);
		k = 0;
		while (s !== v && k < lim) begin
			@(posedge clk);
			k++;
		end
		if (s !== v) begin
			chk(nm, v, s);
			finish_test();
		end
	endtask : wait_sig

	// Address and data are offered together and each is released at its own handshake.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		k = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && k < 50);
		if (k >= 50) wait_sig(s_axi_bvalid, 1'b1, 1, k, "write answer");
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int k;
		k = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && k < 50);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		if (k >= 50) wait_sig(s_axi_rvalid, 1'b1, 1, k, "read answer");
	endtask : rd

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		rd(a, d, r);
		chk(nm, e, d);
		chk("read resp", BCP_RESP_OK, r);
	endtask : rdchk

	// Main sequence: resets, trips, gating, parameter guard and lock, then deep under-voltage.
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		foreach (rst_a[i]) rdchk(rst_a[i], rst_v[i], "reset value");
		rd(8'h28, d, r);
		chk("unmapped resp", BCP_RESP_ERR, r);
		wr(BCP_ADDR_IRQEN, 32'h7F);
		foreach (tk[i]) begin
			wr(BCP_ADDR_SWITCH, 32'h3);
			fault_cmd <= 5'h01 << i;
			wait_sig(discharge_switch, 1'b0, 3000, n, "trip");
			chk("reaction", 1, n >= tk[i] * 2 * OSC_DIV);
			chk("charge switch", 0, charge_switch);
			rdchk(BCP_ADDR_FLAGS, 32'h1 << i, "flag");
			chk("irq", 1, protect_irq);
			wr(BCP_ADDR_SWITCH, 32'h3);
			rdchk(BCP_ADDR_SWITCH, 32'h10, "holdoff");
			wr(BCP_ADDR_FLAGS, 32'h0);
			@(posedge clk);
			chk("irq clear", 0, protect_irq);
			repeat (HOLD) @(posedge clk);
			wr(BCP_ADDR_SWITCH, 32'h3);
			wait_sig(discharge_switch, 1'b0, 3000, n, "retrip");
			fault_cmd <= 5'h00;
			repeat (HOLD) @(posedge clk);
			wr(BCP_ADDR_FLAGS, 32'h0);
		end
		wr(BCP_ADDR_SWITCH, 32'h2);
		fault_cmd <= 5'h0B;
		repeat (600) @(posedge clk);
		chk("discharge gating", 1, charge_switch);
		fault_cmd <= 5'h14;
		wr(BCP_ADDR_SWITCH, 32'h1);
		repeat (600) @(posedge clk);
		chk("charge gating", 1, discharge_switch);
		wr(BCP_ADDR_SWITCH, 32'h9);
		wait_sig(discharge_switch, 1'b0, 3000, n, "recovery trip");
		fault_cmd <= 5'h00;
		wr(BCP_ADDR_SWITCH, 32'h0);
		rdchk(BCP_ADDR_SWITCH, 32'h10, "recovery cleared");
		repeat (HOLD) @(posedge clk);
		wr(BCP_ADDR_UVPARAM, 32'h0105);
		wr(BCP_ADDR_UVPARAM, 32'h0208);
		rdchk(BCP_ADDR_LOCK, 32'h4, "busy");
		repeat (40) @(posedge clk);
		rdchk(BCP_ADDR_UVPARAM, 32'h0105, "guard");
		wr(BCP_ADDR_LOCK, 32'h3);
		wr(BCP_ADDR_LOCK, 32'h1);
		rdchk(BCP_ADDR_LOCK, 32'h1, "lock");
		wr(BCP_ADDR_SCTIME, 32'h7F);
		rdchk(BCP_ADDR_SCTIME, BCP_SCTIME_RST, "locked");
		wr(BCP_ADDR_SWITCH, 32'h7);
		low_cmd <= 1'b1;
		wait_sig(undervolt_early_warning_flag, 1'b1, 3000, n, "warning");
		wait_sig(power_off, 1'b1, 300, n, "power off");
		chk("warning lead", 1, n >= WARN - 2 && n <= WARN + 2);
		repeat (10) @(posedge clk);
		chk("switches off", 3'h0, {discharge_switch, charge_switch, precharge_switch});
		chg_cmd <= 1'b1;
		wait_sig(power_off, 1'b0, 50, n, "wake");
		finish_test();
	end
endmodule : battery_current_protection_tb
`default_nettype wire
